// File: rtl/rxq_top.sv
// receive queue status and collision position top
`timescale 1ns/1ps
`default_nettype none
`include "rxq_defines.svh"
module rxq_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_rd_stb,
    input wire logic [7:0] reg_addr,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic buf_pop,
    input wire logic buf_clear,
    output logic buf_wr_stb,
    output logic [7:0] buf_wr_data,
    input wire logic anticol_mode,
    input wire logic parity_en,
    input wire logic rx_frame_start,
    input wire logic rx_frame_end,
    input wire logic rx_bit_stb,
    input wire logic rx_bit_val,
    input wire logic rx_bit_par,
    input wire logic rx_bit_col,
    input wire logic rx_hard_framing_error,
    output logic hard_framing_error_irq,
    output logic bit_collision_irq
);
    import rxq_pkg::*;

    rxq_if lnk ();
    rxq_main_st_t st_q;
    rxq_main_st_t st_d;

    rxq_count u_count (
        .clock(clock),
        .rst(rst),
        .cif(lnk.cnt_mp)
    );

    rxq_col u_col (
        .clock(clock),
        .rst(rst),
        .cif(lnk.col_mp)
    );

    // register read decode
    function automatic logic [7:0] rd_mux(
        input logic [7:0] addr,
        input logic [9:0] cnt,
        input logic unf,
        input logic ovr,
        input logic [2:0] lb,
        input logic np,
        input logic [7:0] col
    );
        logic [7:0] r;
        r = `RXQ_RD_UNMAPPED;
        case (addr)
            `RXQ_ADDR_STAT_LO: r = cnt[7:0];
            `RXQ_ADDR_STAT_HI: r = {cnt[9:8], unf, ovr, lb, np};
            `RXQ_ADDR_COLL: r = col;
            default: r = `RXQ_RD_UNMAPPED;
        endcase
        return r;
    endfunction

    logic data_bit;
    logic byte_done;
    logic first_col;
    logic col_ok;

    assign data_bit = rx_bit_stb && st_q.in_frame && !rx_bit_par;
    assign byte_done = data_bit && (st_q.bit_cnt == `RXQ_LAST_BIT);
    assign first_col = rx_bit_stb && st_q.in_frame && rx_bit_col && !st_q.col_seen;
    assign col_ok = anticol_mode && (st_q.full_bytes <= `RXQ_MAX_ANTICOL_BYTES);

    // collision capture request
    always_comb
    begin
        lnk.col_stb = first_col && col_ok;
        lnk.col_byte = st_q.full_bytes[3:0];
        lnk.col_bit = rx_bit_par ? 3'h0 : st_q.bit_cnt;
        lnk.col_par = rx_bit_par;
    end

    // counter strobes
    always_comb
    begin
        lnk.push = st_q.wr_stb;
        lnk.pop = buf_pop;
        lnk.clear = buf_clear;
    end

    always_comb
    begin
        st_d = st_q;
        st_d.wr_stb = 1'b0;
        st_d.rd_valid = 1'b0;
        st_d.hfe_irq = rx_hard_framing_error;
        st_d.col_irq = rx_bit_stb && st_q.in_frame && rx_bit_col;
        if (reg_rd_stb)
        begin
            st_d.rd_valid = 1'b1;
            st_d.rd_data = rd_mux(reg_addr, lnk.count, lnk.unf, lnk.ovr,
                st_q.lb_bits, st_q.missing_parity_flag, lnk.col_reg);
        end
        if (rx_frame_start)
        begin
            st_d.in_frame = 1'b1;
            st_d.shift = 8'h00;
            st_d.bit_cnt = 3'h0;
            st_d.par_pend = 1'b0;
            st_d.lb_bits = 3'h0;
            st_d.missing_parity_flag = 1'b0;
            st_d.full_bytes = 5'h00;
            st_d.col_seen = 1'b0;
        end
        else if (rx_frame_end && st_q.in_frame)
        begin
            st_d.in_frame = 1'b0;
            if (st_q.bit_cnt != 3'h0)
            begin
                st_d.wr_stb = 1'b1;
                st_d.wr_data = st_q.shift;
                st_d.lb_bits = st_q.bit_cnt;
                st_d.missing_parity_flag = 1'b0;
            end
            else
            begin
                st_d.lb_bits = 3'h0;
                st_d.missing_parity_flag = st_q.par_pend;
            end
        end
        else if (rx_bit_stb && st_q.in_frame)
        begin
            if (rx_bit_col)
                st_d.col_seen = 1'b1;
            if (rx_bit_par)
                st_d.par_pend = 1'b0;
            else if (byte_done)
            begin
                st_d.wr_stb = 1'b1;
                st_d.wr_data = st_q.shift;
                st_d.wr_data[`RXQ_LAST_BIT] = rx_bit_val;
                st_d.shift = 8'h00;
                st_d.bit_cnt = 3'h0;
                st_d.par_pend = parity_en;
                if (st_q.full_bytes != 5'h1F)
                    st_d.full_bytes = st_q.full_bytes + 5'h01;
            end
            else
            begin
                st_d.shift[st_q.bit_cnt] = rx_bit_val;
                st_d.bit_cnt = st_q.bit_cnt + 3'h1;
                st_d.par_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign reg_rd_data = st_q.rd_data;
    assign reg_rd_valid = st_q.rd_valid;
    assign buf_wr_stb = st_q.wr_stb;
    assign buf_wr_data = st_q.wr_data;
    assign hard_framing_error_irq = st_q.hfe_irq;
    assign bit_collision_irq = st_q.col_irq;

    property p_rd_hi;
        @(posedge clock) disable iff (rst)
        (reg_rd_stb && reg_addr == `RXQ_ADDR_STAT_HI) |=>
            (reg_rd_valid && reg_rd_data[7:6] == $past(lnk.count[9:8])
            && reg_rd_data[5] == $past(lnk.unf) && reg_rd_data[4] == $past(lnk.ovr));
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("second status read wrong");

    property p_rd_lo;
        @(posedge clock) disable iff (rst)
        (reg_rd_stb && reg_addr == `RXQ_ADDR_STAT_LO) |=> (reg_rd_valid && reg_rd_data == $past(lnk.count[7:0]));
    endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("first status read wrong");

    property p_partial;
        @(posedge clock) disable iff (rst)
        (rx_frame_end && !rx_frame_start && st_q.in_frame && st_q.bit_cnt != 3'h0) |=>
            (buf_wr_stb && buf_wr_data == $past(st_q.shift) && st_q.lb_bits == $past(st_q.bit_cnt));
    endproperty
    a_partial: assert property (p_partial) else $error("partial byte not stored in low bits");

    property p_np;
        @(posedge clock) disable iff (rst)
        (rx_frame_end && !rx_frame_start && st_q.in_frame && st_q.bit_cnt == 3'h0 && st_q.par_pend)
            |=> (st_q.missing_parity_flag && st_q.lb_bits == 3'h0);
    endproperty
    a_np: assert property (p_np) else $error("missing parity not flagged");

    property p_hfe;
        @(posedge clock) disable iff (rst)
        rx_hard_framing_error |=> hard_framing_error_irq;
    endproperty
    a_hfe: assert property (p_hfe) else $error("hard framing error flag not raised");

    property p_colirq;
        @(posedge clock) disable iff (rst)
        (rx_bit_stb && st_q.in_frame && rx_bit_col) |=> bit_collision_irq ##1 !bit_collision_irq || $past(rx_bit_col);
    endproperty
    a_colirq: assert property (p_colirq) else $error("collision flag not raised");

    property p_no_long;
        @(posedge clock) disable iff (rst)
        (st_q.full_bytes > `RXQ_MAX_ANTICOL_BYTES || !anticol_mode) |-> !lnk.col_stb;
    endproperty
    a_no_long: assert property (p_no_long) else $error("collision captured outside anticollision");

    property p_first_only;
        @(posedge clock) disable iff (rst)
        (lnk.col_stb && !rx_frame_start) |=> !lnk.col_stb until rx_frame_start;
    endproperty
    a_first_only: assert property (p_first_only) else $error("later collision overwrote first");

    property p_rd_quiet;
        @(posedge clock) disable iff (rst)
        !reg_rd_stb |=> !reg_rd_valid;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read valid without request");

    property p_rd_coll;
        @(posedge clock) disable iff (rst)
        (reg_rd_stb && reg_addr == `RXQ_ADDR_COLL) |=> (reg_rd_valid && reg_rd_data == $past(lnk.col_reg));
    endproperty
    a_rd_coll: assert property (p_rd_coll) else $error("collision register read wrong");

    property p_rd_hi_low;
        @(posedge clock) disable iff (rst)
        (reg_rd_stb && reg_addr == `RXQ_ADDR_STAT_HI) |=>
            (reg_rd_data[3:0] == {$past(st_q.lb_bits), $past(st_q.missing_parity_flag)});
    endproperty
    a_rd_hi_low: assert property (p_rd_hi_low) else $error("last byte fields read wrong");

    property p_byte_store;
        @(posedge clock) disable iff (rst)
        (byte_done && !rx_frame_start && !rx_frame_end) |=>
            (buf_wr_stb && buf_wr_data == {$past(rx_bit_val), $past(st_q.shift[6:0])});
    endproperty
    a_byte_store: assert property (p_byte_store) else $error("full byte not stored lsb first");

    property p_wr_pulse;
        @(posedge clock) disable iff (rst)
        buf_wr_stb |=> !buf_wr_stb;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("byte store longer than one cycle");

    property p_pop_step;
        @(posedge clock) disable iff (rst)
        (buf_pop && !buf_wr_stb && !buf_clear && lnk.count != `RXQ_CNT_RST) |=>
            lnk.count == $past(lnk.count) - 10'h001;
    endproperty
    a_pop_step: assert property (p_pop_step) else $error("count did not step down");

    property p_clear;
        @(posedge clock) disable iff (rst)
        buf_clear |=> (lnk.count == `RXQ_CNT_RST && !lnk.unf && !lnk.ovr);
    endproperty
    a_clear: assert property (p_clear) else $error("clear left count or flags");

    property p_np_alone;
        @(posedge clock) disable iff (rst)
        st_q.missing_parity_flag |-> st_q.lb_bits == 3'h0;
    endproperty
    a_np_alone: assert property (p_np_alone) else $error("missing parity with partial byte");

    property p_last_hold;
        @(posedge clock) disable iff (rst)
        !(rx_frame_start || (rx_frame_end && st_q.in_frame)) |=>
            ($stable(st_q.lb_bits) && $stable(st_q.missing_parity_flag));
    endproperty
    a_last_hold: assert property (p_last_hold) else $error("last byte fields moved inside frame");

    property p_full_bytes;
        @(posedge clock) disable iff (rst)
        (byte_done && !rx_frame_start && !rx_frame_end && st_q.full_bytes != 5'h1F) |=>
            st_q.full_bytes == $past(st_q.full_bytes) + 5'h01;
    endproperty
    a_full_bytes: assert property (p_full_bytes) else $error("full byte count did not step");

    property p_col_par;
        @(posedge clock) disable iff (rst)
        (lnk.col_stb && rx_bit_par) |=> lnk.col_reg[`RXQ_COL_BIT_MSB:`RXQ_COL_PB_BIT] == 4'h1;
    endproperty
    a_col_par: assert property (p_col_par) else $error("parity collision not marked");

    property p_col_data;
        @(posedge clock) disable iff (rst)
        (lnk.col_stb && !rx_bit_par) |=> (!lnk.col_reg[`RXQ_COL_PB_BIT]
            && lnk.col_reg[`RXQ_COL_BIT_MSB:`RXQ_COL_BIT_LSB] == $past(st_q.bit_cnt));
    endproperty
    a_col_data: assert property (p_col_data) else $error("data collision position wrong");

    property p_colirq_quiet;
        @(posedge clock) disable iff (rst)
        !(rx_bit_stb && st_q.in_frame && rx_bit_col) |=> !bit_collision_irq;
    endproperty
    a_colirq_quiet: assert property (p_colirq_quiet) else $error("collision flag without collision");

    property p_hfe_quiet;
        @(posedge clock) disable iff (rst)
        !rx_hard_framing_error |=> !hard_framing_error_irq;
    endproperty
    a_hfe_quiet: assert property (p_hfe_quiet) else $error("framing error flag without error");
endmodule
`default_nettype wire

// File: pkg/rxq_defines.svh
// constants for the receive queue and collision status block
// Contract
// - Buffer byte count is 10 bits: low byte first register, top two in bits 7:6.
// - Bit 5 of second status register shows buffer underflow.
// - Bit 4 of second status register shows buffer overflow.
// - Bits 3:1 of second status register give bits in incomplete last byte.
// - Bits of an incomplete last byte sit in the stored byte's LSBs.
// - Bit 0 of second status register flags eight data bits without parity.
// - Collision register bits 7:4 hold full bytes before the collision.
// - Collision register bits 3:1 hold bits before collision within its byte.
// - Collision register bit 0 set for parity collision, cleared otherwise.
// - Collision register updates only in type-A anticollision frames, never longer ones; code needs anticol_mode and at most 15 full bytes before it.
// - Hard framing error raises the hard framing error interrupt flag.
// - A bit collision during reception raises the bit collision interrupt flag.
`ifndef RXQ_DEFINES_SVH
`define RXQ_DEFINES_SVH
`define RXQ_ADDR_STAT_LO 8'h1E
`define RXQ_ADDR_STAT_HI 8'h1F
`define RXQ_ADDR_COLL 8'h20
`define RXQ_DEPTH 10'h200
`define RXQ_CNT_RST 10'h000
`define RXQ_COLL_RST 8'h00
`define RXQ_RD_UNMAPPED 8'h00
`define RXQ_HI_CNT_MSB 7
`define RXQ_HI_CNT_LSB 6
`define RXQ_HI_UNF_BIT 5
`define RXQ_HI_OVR_BIT 4
`define RXQ_HI_LB_MSB 3
`define RXQ_HI_LB_LSB 1
`define RXQ_HI_NP_BIT 0
`define RXQ_COL_BYTE_MSB 7
`define RXQ_COL_BYTE_LSB 4
`define RXQ_COL_BIT_MSB 3
`define RXQ_COL_BIT_LSB 1
`define RXQ_COL_PB_BIT 0
`define RXQ_MAX_ANTICOL_BYTES 5'h0F
`define RXQ_LAST_BIT 3'h7
`endif

// File: pkg/rxq_pkg.sv
// state types of the receive queue and collision status block
package rxq_pkg;
    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic par_pend;
        logic [2:0] lb_bits;
        logic missing_parity_flag;
        logic in_frame;
        logic [4:0] full_bytes;
        logic col_seen;
        logic [7:0] rd_data;
        logic rd_valid;
        logic wr_stb;
        logic [7:0] wr_data;
        logic hfe_irq;
        logic col_irq;
    } rxq_main_st_t;
    typedef struct packed {
        logic [9:0] cnt;
        logic unf;
        logic ovr;
    } rxq_cnt_st_t;
    typedef struct packed {
        logic [7:0] col_reg;
    } rxq_col_st_t;
endpackage

// File: pkg/rxq_if.sv
// links between the main block, the byte counter and the collision capture
`timescale 1ns/1ps
`default_nettype none
interface rxq_if;
    logic push;
    logic pop;
    logic clear;
    logic [9:0] count;
    logic unf;
    logic ovr;
    logic col_stb;
    logic [3:0] col_byte;
    logic [2:0] col_bit;
    logic col_par;
    logic [7:0] col_reg;
    modport main_mp (output push, pop, clear, col_stb, col_byte, col_bit, col_par,
        input count, unf, ovr, col_reg);
    modport cnt_mp (input push, pop, clear, output count, unf, ovr);
    modport col_mp (input col_stb, col_byte, col_bit, col_par, output col_reg);
endinterface
`default_nettype wire

// File: rtl/rxq_count.sv
// buffer byte counter with underflow and overflow flags
`timescale 1ns/1ps
`default_nettype none
`include "rxq_defines.svh"
module rxq_count (
    input wire logic clock,
    input wire logic rst,
    rxq_if.cnt_mp cif
);
    import rxq_pkg::*;
    rxq_cnt_st_t st_q;
    rxq_cnt_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (cif.clear)
        begin
            st_d.cnt = `RXQ_CNT_RST;
            st_d.unf = 1'b0;
            st_d.ovr = 1'b0;
        end
        else if (cif.push && !cif.pop)
        begin
            if (st_q.cnt == `RXQ_DEPTH)
                st_d.ovr = 1'b1;
            else
                st_d.cnt = st_q.cnt + 10'h001;
        end
        else if (cif.pop && !cif.push)
        begin
            if (st_q.cnt == `RXQ_CNT_RST)
                st_d.unf = 1'b1;
            else
                st_d.cnt = st_q.cnt - 10'h001;
        end
        else if (cif.pop && cif.push && st_q.cnt == `RXQ_CNT_RST)
            st_d.unf = 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign cif.count = st_q.cnt;
    assign cif.unf = st_q.unf;
    assign cif.ovr = st_q.ovr;

    property p_cnt_range;
        @(posedge clock) disable iff (rst) st_q.cnt <= `RXQ_DEPTH;
    endproperty
    a_cnt_range: assert property (p_cnt_range) else $error("count above depth");
    property p_unf;
        @(posedge clock) disable iff (rst)
        (cif.pop && !cif.push && !cif.clear && st_q.cnt == `RXQ_CNT_RST) |=> (st_q.unf && st_q.cnt == `RXQ_CNT_RST);
    endproperty
    a_unf: assert property (p_unf) else $error("underflow not flagged");
    property p_ovr;
        @(posedge clock) disable iff (rst)
        (cif.push && !cif.pop && !cif.clear && st_q.cnt == `RXQ_DEPTH) |=> (st_q.ovr && st_q.cnt == `RXQ_DEPTH);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overflow not flagged or count moved");
    property p_step;
        @(posedge clock) disable iff (rst)
        (cif.push && !cif.pop && !cif.clear && st_q.cnt < `RXQ_DEPTH) |=> st_q.cnt == $past(st_q.cnt) + 10'h001;
    endproperty
    a_step: assert property (p_step) else $error("count did not step up");
endmodule
`default_nettype wire

// File: rtl/rxq_col.sv
// capture of the first collision position
`timescale 1ns/1ps
`default_nettype none
`include "rxq_defines.svh"
module rxq_col (
    input wire logic clock,
    input wire logic rst,
    rxq_if.col_mp cif
);
    import rxq_pkg::*;
    rxq_col_st_t st_q;
    rxq_col_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (cif.col_stb)
        begin
            st_d.col_reg[`RXQ_COL_BYTE_MSB:`RXQ_COL_BYTE_LSB] = cif.col_byte;
            st_d.col_reg[`RXQ_COL_BIT_MSB:`RXQ_COL_BIT_LSB] = cif.col_bit;
            st_d.col_reg[`RXQ_COL_PB_BIT] = cif.col_par;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign cif.col_reg = st_q.col_reg;

    property p_capture;
        @(posedge clock) disable iff (rst)
        cif.col_stb |=> (st_q.col_reg == {$past(cif.col_byte), $past(cif.col_bit), $past(cif.col_par)});
    endproperty
    a_capture: assert property (p_capture) else $error("collision position not captured");
    property p_hold;
        @(posedge clock) disable iff (rst) !cif.col_stb |=> $stable(st_q.col_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("collision register changed without capture");
endmodule
`default_nettype wire

// File: tb/rxq_host_model.sv
// host model reading the status registers and judging field validity
`timescale 1ns/1ps
`default_nettype none
`include "rxq_defines.svh"
module rxq_host_model (
    input wire logic clock,
    output logic reg_rd_stb,
    output logic [7:0] reg_addr,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid,
    input wire logic hard_framing_error_irq
);
    logic hfe_seen = 1'b0;
    initial
    begin
        reg_rd_stb = 1'b0;
        reg_addr = 8'h00;
    end
    // a hard framing error stands until the host acknowledges it
    always @(posedge clock)
        if (hard_framing_error_irq === 1'b1)
            hfe_seen <= 1'b1;
    task automatic ack_error();
        hfe_seen = 1'b0;
    endtask
    // one-cycle read strobe, answer awaited under a bound
    task automatic read(input logic [7:0] a, output logic [7:0] d, output int lat);
        @(posedge clock);
        reg_rd_stb <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd_stb <= 1'b0;
        reg_addr <= ~a;
        #1;
        lat = 1;
        while (reg_rd_valid !== 1'b1 && lat < 8)
        begin
            @(posedge clock);
            #1;
            lat++;
        end
        d = reg_rd_data;
        // fields not trusted while a hard framing error stands
        if (hfe_seen && a == `RXQ_ADDR_STAT_HI)
            d[3:0] = 4'h0;
        if (hfe_seen && a == `RXQ_ADDR_COLL)
            d = 8'h00;
    endtask
endmodule
`default_nettype wire

// File: tb/rx_queue_and_collision_status_tb.sv
// self-checking bench for the receive queue and collision status block
`timescale 1ns/1ps
`default_nettype none
`include "rxq_defines.svh"
module rx_queue_and_collision_status_tb;
    typedef struct packed {
        logic ac;
        logic par;
        logic skip;
        int nbits;
        int kind;
        int at;
        logic [7:0] col;
    } rxq_row_t;
    // kind: 0 none, 1 collision on data bit at, 2 on parity after byte at
    rxq_row_t rows [9] = '{
        '{1'b1, 1'b1, 1'b0, 16, 1, 11, 8'h16},
        '{1'b1, 1'b0, 1'b0, 12, 1, 5, 8'h0A},
        '{1'b0, 1'b1, 1'b0, 8, 1, 3, 8'h0A},
        '{1'b1, 1'b1, 1'b1, 8, 0, 0, 8'h0A},
        '{1'b1, 1'b1, 1'b0, 16, 2, 0, 8'h11},
        '{1'b1, 1'b0, 1'b0, 3, 1, 0, 8'h00},
        '{1'b1, 1'b1, 1'b0, 128, 1, 122, 8'hF4},
        '{1'b1, 1'b0, 1'b0, 136, 1, 130, 8'hF4},
        '{1'b0, 1'b0, 1'b0, 4107, 0, 0, 8'hF4}
    };
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic buf_pop = 1'b0;
    logic buf_clear = 1'b0;
    logic anticol_mode = 1'b0;
    logic parity_en = 1'b0;
    logic rx_frame_start = 1'b0;
    logic rx_frame_end = 1'b0;
    logic rx_bit_stb = 1'b0;
    logic rx_bit_val = 1'b0;
    logic rx_bit_par = 1'b0;
    logic rx_bit_col = 1'b0;
    logic rx_hard_framing_error = 1'b0;
    logic reg_rd_stb;
    logic [7:0] reg_addr;
    logic [7:0] reg_rd_data;
    logic reg_rd_valid;
    logic buf_wr_stb;
    logic [7:0] buf_wr_data;
    logic hard_framing_error_irq;
    logic bit_collision_irq;
    int failures = 0;
    int n_tests = 0;
    int ncol = 0;
    logic [7:0] wq [$];

    always #5 clock = ~clock;

    rxq_top rxq_top_i (.clock, .rst, .reg_rd_stb, .reg_addr, .reg_rd_data, .reg_rd_valid,
        .buf_pop, .buf_clear, .buf_wr_stb, .buf_wr_data, .anticol_mode, .parity_en,
        .rx_frame_start, .rx_frame_end, .rx_bit_stb, .rx_bit_val, .rx_bit_par, .rx_bit_col,
        .rx_hard_framing_error, .hard_framing_error_irq, .bit_collision_irq);
    rxq_host_model rxq_host_model_i (.clock, .reg_rd_stb, .reg_addr, .reg_rd_data,
        .reg_rd_valid, .hard_framing_error_irq);

    // stored bytes and collision pulses
    always @(posedge clock)
    begin
        if (bit_collision_irq === 1'b1)
            ncol++;
        if (buf_wr_stb === 1'b1)
            wq.push_back(buf_wr_data);
    end

    task automatic finish_test();
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // a late or missing answer counts as a mismatch
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        int lat;
        rxq_host_model_i.read(a, d, lat);
        check(lat == 1 ? d : ~e, e);
    endtask

    task automatic bit_out(input logic v, input logic p, input logic c);
        @(posedge clock);
        rx_frame_start <= 1'b0;
        buf_clear <= 1'b0;
        rx_bit_stb <= 1'b1;
        rx_bit_val <= v;
        rx_bit_par <= p;
        rx_bit_col <= c;
    endtask

    task automatic run_row(input rxq_row_t r);
        int nb;
        int rem;
        int c0;
        logic [15:0] pat;
        logic [7:0] eb;
        logic [9:0] cnt;
        pat = 16'hA53C;
        rem = r.nbits % 8;
        nb = (r.nbits + 7) / 8;
        c0 = ncol;
        @(posedge clock);
        anticol_mode <= r.ac;
        parity_en <= r.par;
        rx_frame_start <= 1'b1;
        buf_clear <= 1'b1;
        for (int i = 0; i < r.nbits; i++)
        begin
            bit_out(pat[i % 16], 1'b0, r.kind == 1 && i == r.at);
            if (r.par && i % 8 == 7 && !(r.skip && i == r.nbits - 1))
                bit_out(1'b1, 1'b1, r.kind == 2 && i / 8 == r.at);
        end
        @(posedge clock);
        rx_bit_stb <= 1'b0;
        rx_frame_end <= 1'b1;
        @(posedge clock);
        rx_frame_end <= 1'b0;
        repeat (3) @(posedge clock);
        for (int k = 0; k < nb; k++)
        begin
            eb = (k % 2) ? pat[15:8] : pat[7:0];
            if (k == nb - 1 && rem != 0)
                eb = eb & (8'hFF >> (8 - rem));
            check(wq.size() > 0 ? wq.pop_front() : ~eb, eb);
        end
        cnt = nb > 512 ? 10'h200 : 10'(nb);
        check(8'(ncol - c0), {7'h00, r.kind != 0});
        rd(`RXQ_ADDR_STAT_LO, cnt[7:0]);
        rd(`RXQ_ADDR_STAT_HI, {cnt[9:8], 1'b0, nb > 512, 3'(rem), r.skip});
        rd(`RXQ_ADDR_COLL, r.col);
    endtask

    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(`RXQ_ADDR_STAT_LO, 8'h00);
        rd(`RXQ_ADDR_STAT_HI, 8'h00);
        rd(`RXQ_ADDR_COLL, 8'h00);
        rd(8'h21, `RXQ_RD_UNMAPPED);
        foreach (rows[i])
            run_row(rows[i]);
        // one byte out of the full queue, overflow flag kept
        @(posedge clock);
        buf_pop <= 1'b1;
        @(posedge clock);
        buf_pop <= 1'b0;
        rd(`RXQ_ADDR_STAT_LO, 8'hFF);
        rd(`RXQ_ADDR_STAT_HI, 8'h56);
        // clear, then a pop on the empty queue
        @(posedge clock);
        buf_clear <= 1'b1;
        @(posedge clock);
        buf_clear <= 1'b0;
        buf_pop <= 1'b1;
        @(posedge clock);
        buf_pop <= 1'b0;
        rd(`RXQ_ADDR_STAT_LO, 8'h00);
        rd(`RXQ_ADDR_STAT_HI, 8'h26);
        // hard framing error pulse
        @(posedge clock);
        rx_hard_framing_error <= 1'b1;
        @(posedge clock);
        rx_hard_framing_error <= 1'b0;
        #1;
        check({7'h00, hard_framing_error_irq}, 8'h01);
        @(posedge clock);
        #1;
        check({7'h00, hard_framing_error_irq}, 8'h00);
        rd(`RXQ_ADDR_COLL, 8'h00);
        rd(`RXQ_ADDR_STAT_HI, 8'h20);
        rxq_host_model_i.ack_error();
        rd(`RXQ_ADDR_COLL, 8'hF4);
        rd(`RXQ_ADDR_STAT_HI, 8'h26);
        // reset in mid-run returns every status to zero
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(`RXQ_ADDR_STAT_LO, 8'h00);
        rd(`RXQ_ADDR_STAT_HI, 8'h00);
        rd(`RXQ_ADDR_COLL, 8'h00);
        finish_test();
    end

    initial
    begin
        #300000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
